/* mbhp_pkg.sv */
// package of shared constants and types for the micro bus host port
package mbhp_pkg;
    // ------------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int SPACE_BYTES = 128;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [6:0] ADDR_RESET = 7'h00;
    // ------------------------------------------------------------------
    // strap encodings
    // ------------------------------------------------------------------
    localparam logic STYLE_RDWR = 1'b0;
    localparam logic STYLE_DSRW = 1'b1;
    localparam logic MUX_SEPARATE = 1'b0;
    localparam logic MUX_SHARED = 1'b1;
    // ------------------------------------------------------------------
    // controller timing, in clock cycles
    // ------------------------------------------------------------------
    localparam int PHASE_CYC = 2;
    // ------------------------------------------------------------------
    // controller states
    // ------------------------------------------------------------------
    typedef enum logic [5:0] {
        MBHP_IDLE = 6'b000001,
        MBHP_ALE = 6'b000010,
        MBHP_ADR = 6'b000100,
        MBHP_STB = 6'b001000,
        MBHP_END = 6'b010000,
        MBHP_DONE = 6'b100000
    } mbhp_state_t;
endpackage : mbhp_pkg

/* mbhp_if.sv */
// interface joining the micro bus host port and its controller
`timescale 1ns/1ps
interface mbhp_if;
    logic ale;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [6:0] addr;
    logic [7:0] ad_dev_o;
    logic ad_dev_oe_n;
    logic [7:0] ad_mc_o;
    logic ad_mc_oe_n;
    logic irq_n_o;
    logic irq_oe_n;
    logic [7:0] ad;
    logic irq_n;
    // shared wire: whoever enables, else pulled up
    assign ad = !ad_dev_oe_n ? ad_dev_o : (!ad_mc_oe_n ? ad_mc_o : 8'hFF);
    assign irq_n = !irq_oe_n ? irq_n_o : 1'b1;
    modport dev (
        input ale, cs_n, rd_n, wr_n, addr, ad,
        output ad_dev_o, ad_dev_oe_n, irq_n_o, irq_oe_n
    );
    modport mc (
        output ale, cs_n, rd_n, wr_n, addr, ad_mc_o, ad_mc_oe_n,
        input ad, irq_n
    );
endinterface : mbhp_if

/* mbhp_port.sv */
// device end of the micro bus host port with a 128-byte register space
// How it works
// [R1] 128 one-byte locations read and written
// [R2] style low: ale, cs, read, write strobes
// [R3] style high: ale, cs, data strobe, direction
// [R4] multiplex high: address over shared pins
// [R5] multiplex low: address from seven-bit bus
// [R6] read address caught at ale fall
// [R7] read data driven after cs and strobe
// [R8] read ends at strobe rise, bus released
// [R9] write address caught at ale fall
// [R10] controller drives write data after strobes fall
// [R11] direction low before cs and strobe fall
// [R12] direction high only after strobes rise
// [R13] write data stored at strobe rising edge
// [R14] interrupt request output can be raised
// [R15] separate address bus, same cycle timing
// [R16] cs high: strobes ignored, data pins undriven
`timescale 1ns/1ps
module mbhp_port (
    input wire logic clk_i,
    input wire logic rstn_i,
    mbhp_if.dev bus,
    input wire logic bus_style_select_i,
    input wire logic bus_multiplex_select_i,
    input wire logic irq_req_i,
    output logic irq_active_o
);
    // ------------------------------------------------------------------
    // storage and state
    // ------------------------------------------------------------------
    logic [7:0] mem_r [mbhp_pkg::SPACE_BYTES];
    // address latch
    logic ale_r;
    logic ale_nxt;
    logic ale_fall;
    logic [6:0] addr_r;
    logic [6:0] addr_nxt;
    logic [6:0] addr_src;
    // write capture
    logic wstb_r;
    logic wstb_nxt;
    logic [7:0] wdat_r;
    logic [7:0] wdat_nxt;
    logic wr_fire;
    // read data
    logic rd_act_r;
    logic rd_act_nxt;
    logic [7:0] dout_r;
    logic [7:0] dout_nxt;
    // interrupt request
    logic irq_r;
    logic irq_nxt;
    // strobe decode
    logic rd_en;
    logic wr_en;

    // ------------------------------------------------------------------
    // strobe decode
    // ------------------------------------------------------------------
    // returns {read enable, write enable} for one set of pin levels
    function automatic logic [1:0] mbhp_strobes(
        input logic style,
        input logic sel_n,
        input logic rstb_n,
        input logic wstb_n
    );
        logic [1:0] en;
        en = 2'b00;
        if (sel_n) begin
            // [R16] chip select high ignores strobes
            en = 2'b00;
        end else if (style == mbhp_pkg::STYLE_DSRW) begin
            // [R3] data strobe with direction on wr_n
            en = {!rstb_n && wstb_n, !rstb_n && !wstb_n};
        end else begin
            // [R2] separate active-low strobes
            en = {!rstb_n, !wstb_n};
        end
        return en;
    endfunction : mbhp_strobes

    always_comb begin
        {rd_en, wr_en} = mbhp_strobes(bus_style_select_i, bus.cs_n,
                                      bus.rd_n, bus.wr_n);
    end

    // ------------------------------------------------------------------
    // address latch
    // ------------------------------------------------------------------
    // [R6] [R9] falling edge of ale seen on the clock
    assign ale_fall = ale_r && !bus.ale;

    // [R4] [R5] [R15] address source by strap
    always_comb begin
        if (bus_multiplex_select_i == mbhp_pkg::MUX_SHARED) begin
            addr_src = bus.ad[6:0];
        end else begin
            addr_src = bus.addr;
        end
    end

    always_comb begin
        ale_nxt = bus.ale;
        addr_nxt = addr_r;
        if (ale_fall) begin
            addr_nxt = addr_src;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ale_r <= 1'b0;
            addr_r <= mbhp_pkg::ADDR_RESET;
        end else begin
            ale_r <= ale_nxt;
            addr_r <= addr_nxt;
        end
    end

    // ------------------------------------------------------------------
    // write capture
    // ------------------------------------------------------------------
    // [R13] store on rising write strobe
    assign wr_fire = wstb_r && !wr_en;

    always_comb begin
        wstb_nxt = wr_en;
        wdat_nxt = wdat_r;
        // bus may float once the strobe rises, so keep the last byte
        if (wr_en) begin
            wdat_nxt = bus.ad;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            wstb_r <= 1'b0;
            wdat_r <= mbhp_pkg::DATA_RESET;
        end else begin
            wstb_r <= wstb_nxt;
            wdat_r <= wdat_nxt;
        end
    end

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    always_comb begin
        // [R7] [R8] drive while read strobe stays low
        rd_act_nxt = rd_en;
        // [R1] one-byte locations, looked up a cycle ahead
        dout_nxt = mem_r[addr_r];
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rd_act_r <= 1'b0;
            dout_r <= mbhp_pkg::DATA_RESET;
        end else begin
            rd_act_r <= rd_act_nxt;
            dout_r <= dout_nxt;
        end
    end

    // ------------------------------------------------------------------
    // interrupt request
    // ------------------------------------------------------------------
    always_comb begin
        // [R14] interrupt request follows event input
        // registered so the pin never glitches
        irq_nxt = irq_req_i;
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    // ------------------------------------------------------------------
    // register space
    // ------------------------------------------------------------------
    // the array itself holds no reset
    always_ff @(posedge clk_i) begin
        // [R13] write data taken from shared bus
        if (wr_fire) begin
            mem_r[addr_r] <= wdat_r;
        end
    end

    // ------------------------------------------------------------------
    // data pins
    // ------------------------------------------------------------------
    // [R8] [R16] release bus when read ends or cs high
    // enable is low while the port drives
    assign bus.ad_dev_oe_n = !(rd_act_r && rd_en);
    assign bus.ad_dev_o = dout_r;

    // ------------------------------------------------------------------
    // interrupt pin
    // ------------------------------------------------------------------
    // open drain: drive low only
    assign bus.irq_n_o = 1'b0;
    assign bus.irq_oe_n = !irq_r;
    assign irq_active_o = irq_r;
endmodule : mbhp_port

/* mbhp_ctrl.sv */
// controller end: runs one byte read or write over the micro bus
`timescale 1ns/1ps
module mbhp_ctrl (
    input wire logic clk_i,
    input wire logic rstn_i,
    mbhp_if.mc bus,
    input wire logic bus_style_select_i,
    input wire logic bus_multiplex_select_i,
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [6:0] req_addr_i,
    input wire logic [7:0] req_wdata_i,
    output logic req_ready_o,
    output logic rsp_valid_o,
    output logic [7:0] rsp_rdata_o,
    output logic irq_o
);
    mbhp_pkg::mbhp_state_t st_r, st_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic wr_r, wr_nxt;
    logic [6:0] a_r, a_nxt;
    logic [7:0] d_r, d_nxt;
    logic [7:0] rd_r, rd_nxt;
    logic vld_r, vld_nxt;
    logic phase_done;

    assign phase_done = (cnt_r == 2'(mbhp_pkg::PHASE_CYC - 1));

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = phase_done ? 2'h0 : cnt_r + 2'h1;
        wr_nxt = wr_r;
        a_nxt = a_r;
        d_nxt = d_r;
        rd_nxt = rd_r;
        vld_nxt = 1'b0;
        unique case (st_r)
            mbhp_pkg::MBHP_IDLE: begin
                cnt_nxt = 2'h0;
                if (req_valid_i) begin
                    st_nxt = mbhp_pkg::MBHP_ALE;
                    wr_nxt = req_write_i;
                    a_nxt = req_addr_i;
                    d_nxt = req_wdata_i;
                end
            end
            mbhp_pkg::MBHP_ALE: if (phase_done) st_nxt = mbhp_pkg::MBHP_ADR;
            mbhp_pkg::MBHP_ADR: if (phase_done) st_nxt = mbhp_pkg::MBHP_STB;
            mbhp_pkg::MBHP_STB: begin
                if (phase_done) begin
                    st_nxt = mbhp_pkg::MBHP_END;
                    rd_nxt = bus.ad;
                end
            end
            mbhp_pkg::MBHP_END: if (phase_done) st_nxt = mbhp_pkg::MBHP_DONE;
            mbhp_pkg::MBHP_DONE: begin
                st_nxt = mbhp_pkg::MBHP_IDLE;
                vld_nxt = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            st_r <= mbhp_pkg::MBHP_IDLE;
            cnt_r <= 2'h0;
            wr_r <= 1'b0;
            a_r <= mbhp_pkg::ADDR_RESET;
            d_r <= mbhp_pkg::DATA_RESET;
            rd_r <= mbhp_pkg::DATA_RESET;
            vld_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            wr_r <= wr_nxt;
            a_r <= a_nxt;
            d_r <= d_nxt;
            rd_r <= rd_nxt;
            vld_r <= vld_nxt;
        end
    end

    // ------------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------------
    logic busy, shared_adr;
    assign busy = (st_r != mbhp_pkg::MBHP_IDLE);
    // [R6] address held past the ale fall so the port can latch it
    assign shared_adr = (bus_multiplex_select_i == mbhp_pkg::MUX_SHARED)
                        && (st_r == mbhp_pkg::MBHP_ALE
                            || st_r == mbhp_pkg::MBHP_ADR);
    assign bus.ale = (st_r == mbhp_pkg::MBHP_ALE);
    assign bus.cs_n = (st_r != mbhp_pkg::MBHP_STB);
    // [R15] separate bus carries address for whole cycle
    assign bus.addr = a_r;
    always_comb begin
        if (bus_style_select_i == mbhp_pkg::STYLE_DSRW) begin
            // [R11] [R12] direction held low around strobe
            bus.rd_n = (st_r != mbhp_pkg::MBHP_STB);
            bus.wr_n = !(busy && wr_r && st_r != mbhp_pkg::MBHP_DONE);
        end else begin
            bus.rd_n = !(st_r == mbhp_pkg::MBHP_STB && !wr_r);
            bus.wr_n = !(st_r == mbhp_pkg::MBHP_STB && wr_r);
        end
    end
    // [R10] write data driven once strobes are low
    assign bus.ad_mc_oe_n = !(shared_adr
                              || (st_r == mbhp_pkg::MBHP_STB && wr_r));
    assign bus.ad_mc_o = shared_adr ? {1'b0, a_r} : d_r;
    assign req_ready_o = !busy;
    assign rsp_valid_o = vld_r;
    assign rsp_rdata_o = rd_r;
    assign irq_o = !bus.irq_n;
endmodule : mbhp_ctrl

/* mbhp_link_sva.sv */
// concurrent checks on the wires between port and controller
`timescale 1ns/1ps
module mbhp_link_sva (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic bus_style_select_i,
    input wire logic ale,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic ad_dev_oe_n,
    input wire logic ad_mc_oe_n
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // ------------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------------
    sequence s_read_stb;
        (!cs_n && !rd_n && wr_n) [*2];
    endsequence
    sequence s_cs_pulse;
        !cs_n ##1 cs_n;
    endsequence
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_idle_no_drive: assert property (cs_n |-> ad_dev_oe_n)
        else $error("port drives data while deselected");
    a_strobe_up_release: assert property (rd_n |-> ad_dev_oe_n)
        else $error("port drives data with strobe high");
    a_first_cyc_quiet: assert property (
        (!cs_n && !rd_n && $past(rd_n)) |-> ad_dev_oe_n)
        else $error("port drives data in first strobe cycle");
    a_read_drives: assert property (s_read_stb |-> !ad_dev_oe_n)
        else $error("port does not drive read data");
    a_no_contention: assert property (!(!ad_dev_oe_n && !ad_mc_oe_n))
        else $error("both ends drive the shared bus");
    a_ale_outside_cs: assert property (ale |-> cs_n)
        else $error("address latch enable inside a select");
    a_strobe_length: assert property ($fell(cs_n) |=> s_cs_pulse)
        else $error("select low not two cycles");
    a_dir_leads_cs: assert property (
        (bus_style_select_i && $fell(cs_n) && !wr_n) |-> $past(!wr_n))
        else $error("direction did not fall before select");
    a_dir_trails_cs: assert property (
        (bus_style_select_i && $rose(wr_n)) |-> $past(cs_n && rd_n))
        else $error("direction rose before select released");
endmodule : mbhp_link_sva

/* test_micro_bus_host_port.sv */
// testbench joining both ends of the micro bus host port
`timescale 1ns/1ps
module test_micro_bus_host_port;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic style = 1'b0;
    logic mux = 1'b0;
    logic irq_req = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [6:0] req_addr = 7'h00;
    logic [7:0] req_wdata = 8'h00;
    logic req_ready, rsp_valid, irq_o, irq_active;
    logic [7:0] rsp_rdata;
    logic [7:0] rd;
    logic [7:0] wd;
    logic [6:0] adr [3] = '{7'h00, 7'h7F, 7'h55};
    int err_count = 0;
    int compares = 0;
    int cycles = 0;
    always #2.5 clk_i = ~clk_i;
    mbhp_if mbhp_if_inst ();
    mbhp_port mbhp_port_inst (.clk_i(clk_i), .rstn_i(rstn_i),
        .bus(mbhp_if_inst.dev), .bus_style_select_i(style),
        .bus_multiplex_select_i(mux), .irq_req_i(irq_req),
        .irq_active_o(irq_active));
    mbhp_ctrl mbhp_ctrl_inst (.clk_i(clk_i), .rstn_i(rstn_i),
        .bus(mbhp_if_inst.mc), .bus_style_select_i(style),
        .bus_multiplex_select_i(mux), .req_valid_i(req_valid),
        .req_write_i(req_write), .req_addr_i(req_addr),
        .req_wdata_i(req_wdata), .req_ready_o(req_ready),
        .rsp_valid_o(rsp_valid), .rsp_rdata_o(rsp_rdata), .irq_o(irq_o));
    mbhp_link_sva mbhp_link_sva_inst (.clk_i(clk_i), .rstn_i(rstn_i),
        .bus_style_select_i(style), .ale(mbhp_if_inst.ale),
        .cs_n(mbhp_if_inst.cs_n), .rd_n(mbhp_if_inst.rd_n),
        .wr_n(mbhp_if_inst.wr_n), .ad_dev_oe_n(mbhp_if_inst.ad_dev_oe_n),
        .ad_mc_oe_n(mbhp_if_inst.ad_mc_oe_n));
    task automatic give_verdict;
        if (err_count == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [6:0] a,
        input logic [7:0] d, output logic [7:0] q);
        int n;
        @(posedge clk_i);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_wdata <= d;
        @(posedge clk_i);
        req_valid <= 1'b0;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_i);
            #1;
            // busy controller refuses new requests
            if (n == 0) chk({7'h00, req_ready}, 8'h00);
            if (rsp_valid === 1'b1) break;
        end
        if (n == 20) chk(8'hEE, 8'h00);
        chk({7'h00, req_ready}, 8'h01);
        q = rsp_rdata;
    endtask : xfer
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            give_verdict();
        end
    end
    initial begin
        repeat (16) @(posedge clk_i);
        rstn_i <= 1'b1;
        // every strap pair, edges of the space and a middle address
        for (int m = 0; m < 4; m++) begin
            style <= m[0];
            mux <= m[1];
            for (int i = 0; i < 3; i++) begin
                wd = 8'h3C ^ {m[1:0], adr[i][5:0]};
                xfer(1'b1, adr[i], wd, rd);
            end
            for (int i = 0; i < 3; i++) begin
                xfer(1'b0, adr[i], 8'h00, rd);
                chk(rd, 8'h3C ^ {m[1:0], adr[i][5:0]});
            end
        end
        irq_req <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk({6'h00, irq_o, irq_active}, 8'h03);
        irq_req <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk({6'h00, irq_o, irq_active}, 8'h00);
        // reset in mid-run leaves the register space intact
        rstn_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        xfer(1'b0, adr[1], 8'h00, rd);
        chk(rd, 8'h3C ^ {2'b11, adr[1][5:0]});
        give_verdict();
    end
endmodule : test_micro_bus_host_port
